// [rtl/rls_regs.sv]
// Function
// [RULE1] Registers are read-only monitors of live signals; IRQ mask and frame config are writable here, IRQ status is write-1-clear
// [RULE2] Arrival count sits in bits 10:3
// [RULE3] Arrival count limited to (FxK/4)-1 down to 0
// [RULE4] Count zero means arrival at boundary
// [RULE5] Count n means n link clocks early
// [RULE6] Software keeps release offset two clocks away
// [RULE7] Bit 0 mirrors the sync request level
// [RULE8] Lane empty flags at bits 23:16
// [RULE9] Lane full flags at bits 7:0
// [RULE10] Low sync level requests reinitialisation
// [RULE11] Reserved bits read zero, writes ignored
`default_nettype none
module rls_regs
  import rls_pkg::*;
(
  // System
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Wishbone slave
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [7:0]               adr_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic [31:0]              dat_i,
  output logic      [31:0]              dat_o,
  output logic                          ack_o,
  output logic                          err_o,
  // Receiver signals from the link domain
  input  wire logic                     sync_req_n_i,
  input  wire logic [RLS_ARRIVAL_W-1:0] arrival_count_i,
  input  wire logic [RLS_LANES-1:0]     lane_phase_fifo_full_flag_i,
  input  wire logic [RLS_LANES-1:0]     lane_phase_fifo_empty_flag_i,
  // Interrupt
  output logic                          irq_o
);
  rls_live_t                live_async;
  rls_live_t                live;
  logic                     sync_d_reg;
  logic [RLS_LANES-1:0]     full_d_reg;
  logic [RLS_LANES-1:0]     empty_d_reg;
  logic [RLS_IRQ_W-1:0]     status_reg;
  logic [RLS_IRQ_W-1:0]     status_next;
  logic [RLS_IRQ_W-1:0]     mask_reg;
  logic [RLS_FK_W-1:0]      fk_reg;
  logic [15:0]              range_cnt_reg;
  logic [RLS_IRQ_W-1:0]     events;
  logic [RLS_IRQ_W-1:0]     clear_bits;
  logic [31:0]              clear_word;
  logic [RLS_ARRIVAL_W-1:0] arrival_prev_reg;
  logic [RLS_ARRIVAL_W-1:0] arrival_held_reg;
  logic                     arrival_steady;
  logic [RLS_FK_W-1:0]      arrival_limit;
  logic                     out_of_range;
  logic                     req;
  logic                     wr;
  logic                     hit_align;
  logic                     hit_fifo;
  logic                     hit_status;
  logic                     hit_mask;
  logic                     hit_cfg;
  logic                     hit_cnt;
  logic                     mapped;
  logic [31:0]              rd_word;
  logic [31:0]              align_word;
  logic [31:0]              fifo_word;

  function automatic logic [31:0] lane_mask(input logic [31:0] w, input logic [3:0] s);
    lane_mask = w & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  assign live_async.sync_req_n = sync_req_n_i;
  assign live_async.arrival    = arrival_count_i;
  assign live_async.pc_full    = lane_phase_fifo_full_flag_i;
  assign live_async.pc_empty   = lane_phase_fifo_empty_flag_i;

  // Inputs come from the link clock domain
  rls_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (live_async),
    .sync_o  (live)
  );

  // The count is several bits wide and crosses clocks with no handshake:
  // it is taken only once two synchronised samples agree, so a torn word never shows
  assign arrival_steady = (live.arrival == arrival_prev_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arrival_prev_reg <= '0;
      arrival_held_reg <= '0;
    end else begin
      arrival_prev_reg <= live.arrival;
      if (arrival_steady)
        arrival_held_reg <= live.arrival;
    end
  end

  // Bus decode
  assign req        = cyc_i & stb_i & ~ack_o & ~err_o;
  assign wr         = req & we_i;
  assign hit_align  = (adr_i == RLS_ADDR_ALIGN_STATUS);
  assign hit_fifo   = (adr_i == RLS_ADDR_FIFO_FLAGS);
  assign hit_status = (adr_i == RLS_ADDR_IRQ_STATUS);
  assign hit_mask   = (adr_i == RLS_ADDR_IRQ_MASK);
  assign hit_cfg    = (adr_i == RLS_ADDR_FRAME_CFG);
  assign hit_cnt    = (adr_i == RLS_ADDR_ERR_COUNT);
  assign mapped     = hit_align | hit_fifo | hit_status | hit_mask | hit_cfg | hit_cnt;

  // Live monitors, reserved bits zero
  assign align_word = RLS_RESET_WORD
                    | (32'(arrival_held_reg) << RLS_ARRIVAL_LSB)                // [RULE2] [RULE4] [RULE5]
                    | (32'(live.sync_req_n) << RLS_SYNC_BIT);                   // [RULE7] [RULE10]
  assign fifo_word  = RLS_RESET_WORD
                    | (32'(live.pc_empty) << RLS_EMPTY_LSB)                     // [RULE8]
                    | (32'(live.pc_full) << RLS_FULL_LSB);                      // [RULE9] [RULE11]

  assign rd_word = hit_align  ? align_word :                                    // [RULE1]
                   hit_fifo   ? fifo_word :
                   hit_status ? 32'(status_reg) :
                   hit_mask   ? 32'(mask_reg) :
                   hit_cfg    ? 32'(fk_reg) :
                   hit_cnt    ? 32'(range_cnt_reg) : 32'h0000_0000;

  // Legal arrival range is FxK/4 - 1 down to 0; FxK is programmed by software
  assign arrival_limit = (fk_reg >> 2) - 11'h001;
  assign out_of_range  = (11'(arrival_held_reg) > arrival_limit);               // [RULE3]

  // Events: sync request falling edge, any full or empty rising edge, count out of range
  assign events[RLS_IRQ_SYNC]  = sync_d_reg & ~live.sync_req_n;                 // [RULE10]
  assign events[RLS_IRQ_FULL]  = |(live.pc_full & ~full_d_reg);
  assign events[RLS_IRQ_EMPTY] = |(live.pc_empty & ~empty_d_reg);
  assign events[RLS_IRQ_RANGE] = out_of_range;

  assign clear_word  = (wr && hit_status) ? lane_mask(dat_i, sel_i) : 32'h0000_0000;
  assign clear_bits  = clear_word[RLS_IRQ_W-1:0];
  // Set wins over a simultaneous clear
  assign status_next = (status_reg & ~clear_bits) | events;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= RLS_RESET_WORD;
    end else begin
      ack_o <= req & mapped;
      err_o <= req & ~mapped;
      dat_o <= (req & ~we_i) ? rd_word : RLS_RESET_WORD;
    end
  end

  // Writes to the two monitors fall through with no effect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= RLS_MASK_RESET;
      fk_reg   <= RLS_FK_RESET;
    end else begin
      if (wr && hit_mask && sel_i[0])
        mask_reg <= dat_i[RLS_IRQ_W-1:0];
      if (wr && hit_cfg && sel_i[0])
        fk_reg[7:0] <= dat_i[7:0];
      if (wr && hit_cfg && sel_i[1])
        fk_reg[RLS_FK_W-1:8] <= dat_i[RLS_FK_W-1:8];
    end
  end                                                                           // [RULE11]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg    <= '0;
      sync_d_reg    <= 1'b0;
      full_d_reg    <= '0;
      empty_d_reg   <= '0;
      range_cnt_reg <= '0;
      irq_o         <= 1'b0;
    end else begin
      status_reg  <= status_next;
      sync_d_reg  <= live.sync_req_n;
      full_d_reg  <= live.pc_full;
      empty_d_reg <= live.pc_empty;
      if (out_of_range && range_cnt_reg != 16'hFFFF)
        range_cnt_reg <= range_cnt_reg + 16'h0001;
      irq_o <= |(status_next & mask_reg);
    end
  end

  // Assertions
  ack_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held two cycles");
  ack_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && mapped) |=> ack_o && !err_o) else $error("mapped access not acked");
  err_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !mapped) |=> err_o && !ack_o) else $error("unmapped access not errored");
  arrival_field_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    (req && !we_i && hit_align) |=> dat_o[10:3] == $past(arrival_held_reg)) else $error("arrival");
  sync_bit_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE7]
    (req && !we_i && hit_align) |=> dat_o[0] == $past(live.sync_req_n)) else $error("sync bit");
  empty_field_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    (req && !we_i && hit_fifo) |=> dat_o[23:16] == $past(live.pc_empty)) else $error("empty");
  full_field_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
    (req && !we_i && hit_fifo) |=> dat_o[7:0] == $past(live.pc_full)) else $error("full");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
    (req && !we_i && hit_fifo) |=>
      (dat_o & 32'hFF00_FF00) == 32'h0000_0000) else $error("reserved");
  align_rsvd_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
    (req && !we_i && hit_align) |=> (dat_o & 32'hFFFF_F806) == 32'h0000_0000)
    else $error("align reserved");
  sync_event_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE10]
    ($fell(live.sync_req_n)) |=> status_reg[RLS_IRQ_SYNC]) else $error("sync event lost");
  range_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    out_of_range |=> status_reg[RLS_IRQ_RANGE]) else $error("range flag lost");
  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (irq_o == |(status_reg & $past(mask_reg)))) else $error("irq level wrong");

  // Bus handshake
  err_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    err_o |=> !err_o) else $error("err held two cycles");
  ack_err_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(ack_o && err_o)) else $error("ack and err together");
  req_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o && !err_o) |=> (ack_o || err_o)) else $error("no answer");
  ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> $past(req && mapped)) else $error("ack without request");
  err_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    err_o |-> $past(req && !mapped)) else $error("err without request");
  dat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == 32'h0000_0000) else $error("read data outside ack");
  write_dat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i) |=> dat_o == 32'h0000_0000) else $error("read data on write");

  // Readback of the control side
  status_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && hit_status) |=> dat_o == 32'($past(status_reg))) else $error("status read");
  mask_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && hit_mask) |=> dat_o == 32'($past(mask_reg))) else $error("mask read");
  cfg_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && hit_cfg) |=> dat_o == 32'($past(fk_reg))) else $error("cfg read");
  cnt_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && hit_cnt) |=> dat_o == 32'($past(range_cnt_reg))) else $error("count read");

  // Writable registers
  mask_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_mask && sel_i[0]) |=> mask_reg == $past(dat_i[3:0])) else $error("mask write");
  mask_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_mask) |=> $stable(mask_reg)) else $error("mask changed");
  cfg_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_cfg && sel_i[0]) |=> fk_reg[7:0] == $past(dat_i[7:0])) else $error("cfg low");
  cfg_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_cfg && sel_i[1]) |=> fk_reg[10:8] == $past(dat_i[10:8])) else $error("cfg high");
  cfg_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && hit_cfg) |=> $stable(fk_reg)) else $error("cfg changed");
  monitor_nowrite_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE11]
    (wr && (hit_align || hit_fifo)) |=> $stable(mask_reg) && $stable(fk_reg))
    else $error("monitor write took effect");

  // Sticky status
  full_event_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
    events[RLS_IRQ_FULL] |=> status_reg[RLS_IRQ_FULL]) else $error("full event lost");
  empty_event_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
    events[RLS_IRQ_EMPTY] |=> status_reg[RLS_IRQ_EMPTY]) else $error("empty event lost");
  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_status && events != 4'h0) |=> (status_reg & $past(events)) == $past(events))
    else $error("clear beat set");
  clear_works_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit_status && sel_i[0] && dat_i[0] && !events[0]) |=> !status_reg[0])
    else $error("clear ignored");
  status_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!(wr && hit_status) && events == 4'h0) |=> $stable(status_reg))
    else $error("status changed");

  // Range counter and captured count
  cnt_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE3]
    (out_of_range && range_cnt_reg != 16'hFFFF) |=>
      range_cnt_reg == $past(range_cnt_reg) + 16'h0001) else $error("count step");
  cnt_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (range_cnt_reg == 16'hFFFF) |=> range_cnt_reg == 16'hFFFF) else $error("count wrapped");
  cnt_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !out_of_range |=> $stable(range_cnt_reg)) else $error("count moved");
  arrival_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
    !arrival_steady |=> $stable(arrival_held_reg)) else $error("torn count taken");

  // Interrupt gating
  irq_masked_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mask_reg == 4'h0) |=> !irq_o) else $error("masked irq");
  irq_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (status_reg == 4'h0 && events == 4'h0) |=> !irq_o) else $error("irq without status");
endmodule // rls_regs
`default_nettype wire

// [shared/rls_pkg.sv]
`default_nettype none
package rls_pkg;
  // Register byte addresses
  localparam logic [7:0]  RLS_ADDR_ALIGN_STATUS = 8'h00;
  localparam logic [7:0]  RLS_ADDR_FIFO_FLAGS   = 8'h04;
  localparam logic [7:0]  RLS_ADDR_IRQ_STATUS   = 8'h08;
  localparam logic [7:0]  RLS_ADDR_IRQ_MASK     = 8'h0C;
  localparam logic [7:0]  RLS_ADDR_FRAME_CFG    = 8'h10;
  localparam logic [7:0]  RLS_ADDR_ERR_COUNT    = 8'h14;
  // Field positions
  localparam int          RLS_SYNC_BIT          = 0;
  localparam int          RLS_ARRIVAL_LSB       = 3;
  localparam int          RLS_ARRIVAL_W         = 8;
  localparam int          RLS_FULL_LSB          = 0;
  localparam int          RLS_EMPTY_LSB         = 16;
  localparam int          RLS_LANES             = 8;
  localparam int          RLS_FK_W              = 11;
  // Interrupt status bits
  localparam int          RLS_IRQ_SYNC          = 0;
  localparam int          RLS_IRQ_FULL          = 1;
  localparam int          RLS_IRQ_EMPTY         = 2;
  localparam int          RLS_IRQ_RANGE         = 3;
  localparam int          RLS_IRQ_W             = 4;
  // Reset values
  localparam logic [31:0] RLS_RESET_WORD        = 32'h0000_0000;
  localparam logic [RLS_FK_W-1:0] RLS_FK_RESET  = 11'h400;
  localparam logic [3:0]  RLS_MASK_RESET        = 4'h0;

  typedef struct packed {
    logic                    sync_req_n;
    logic [RLS_ARRIVAL_W-1:0] arrival;
    logic [RLS_LANES-1:0]    pc_full;
    logic [RLS_LANES-1:0]    pc_empty;
  } rls_live_t;
endpackage : rls_pkg
`default_nettype wire

// [rtl/rls_sync.sv]
`default_nettype none
module rls_sync
  import rls_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  // Asynchronous input and synchronised output
  input  wire rls_live_t async_i,
  output var  rls_live_t sync_o
);
  rls_live_t stage1_reg;

  // Arrival count is a multi-bit value; it is meant to be quasi-static in the link domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1_reg <= '0;
      sync_o     <= '0;
    end else begin
      stage1_reg <= async_i;
      sync_o     <= stage1_reg;
    end
  end
endmodule // rls_sync
`default_nettype wire

// [bench/tb_rx_link_status_registers.sv]
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_rx_link_status_registers import rls_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        err_o;
  logic        irq_o;
  logic        sync_req_n_i;
  logic [7:0]  arrival_count_i;
  logic [7:0]  full_flags;
  logic [7:0]  empty_flags;
  logic [31:0] q;
  logic        e;
  int          mismatches = 0;
  int          n_checks = 0;
  int          seed = 50254;

  rls_regs uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .sync_req_n_i(sync_req_n_i), .arrival_count_i(arrival_count_i),
    .lane_phase_fifo_full_flag_i(full_flags), .lane_phase_fifo_empty_flag_i(empty_flags),
    .irq_o(irq_o));

  function automatic logic [31:0] exp_align(logic s, logic [7:0] a);
    return {21'h000000, a, 2'b00, s};
  endfunction

  function automatic logic [31:0] exp_flags(logic [7:0] f, logic [7:0] m);
    return {8'h00, m, 8'h00, f};
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Idle cycle before each request keeps cyc/stb low between transfers
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    q = dat_o;
    e = err_o;
    if (n >= 20) mismatches++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  // Link inputs cross two flops, so give them time to settle
  task automatic fire(int k);
    sync_req_n_i <= 1'b1;
    full_flags   <= 8'h00;
    empty_flags  <= 8'h00;
    repeat (6) @(posedge clk_i);
    if (k == 0) sync_req_n_i <= 1'b0;
    if (k == 1) full_flags <= 8'h80;
    if (k == 2) empty_flags <= 8'h01;
    repeat (6) @(posedge clk_i);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    conclude();
  end

  initial begin
    logic [31:0] r;
    logic        s;
    logic [7:0]  a;
    logic [7:0]  f;
    logic [7:0]  m;
    logic [7:0]  rel;
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {1'b1, 47'h0};
    sel_i = 4'hF;
    {sync_req_n_i, arrival_count_i, full_flags, empty_flags} = 25'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, RLS_ADDR_ALIGN_STATUS, 32'h0);
    `CHK(q, RLS_RESET_WORD)
    wb(1'b0, RLS_ADDR_FIFO_FLAGS, 32'h0);
    `CHK(q, RLS_RESET_WORD)
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      s = r[0];
      a = (i < 2) ? i[7:0] : r[8:1];
      f = (i == 2) ? 8'hFF : r[16:9];
      m = (i == 3) ? 8'hFF : r[24:17];
      sync_req_n_i    <= s;
      arrival_count_i <= a;
      full_flags      <= f;
      empty_flags     <= m;
      repeat (5) @(posedge clk_i);
      if (i[0]) wb(1'b1, RLS_ADDR_ALIGN_STATUS, r);
      wb(1'b0, RLS_ADDR_ALIGN_STATUS, 32'h0);
      `CHK(q, exp_align(s, a))
      // Software places the release offset two clocks from the reported count
      rel = q[10:3] + 8'h02;
      `CHK(8'(rel - a), 8'h02)
      if (i[1]) wb(1'b1, RLS_ADDR_FIFO_FLAGS, ~r);
      wb(1'b0, RLS_ADDR_FIFO_FLAGS, 32'h0);
      `CHK(q, exp_flags(f, m))
    end
    $display("test live readback done");
    wb(1'b0, 8'h18, 32'h0);
    `CHK(e, 1'b1)
    wb(1'b0, RLS_ADDR_FRAME_CFG, 32'h0);
    `CHK(q[10:0], RLS_FK_RESET)
    // A small FxK puts a count of 0x10 above the legal top of 3
    wb(1'b1, RLS_ADDR_FRAME_CFG, 32'h0000_0010);
    arrival_count_i <= 8'h10;
    repeat (6) @(posedge clk_i);
    wb(1'b0, RLS_ADDR_IRQ_STATUS, 32'h0);
    `CHK(q[RLS_IRQ_RANGE], 1'b1)
    wb(1'b0, RLS_ADDR_ERR_COUNT, 32'h0);
    `CHK(q[15:0] != 16'h0000, 1'b1)
    wb(1'b1, RLS_ADDR_FRAME_CFG, 32'(RLS_FK_RESET));
    wb(1'b0, RLS_ADDR_FRAME_CFG, 32'h0);
    `CHK(q[10:0], RLS_FK_RESET)
    $display("test map done");
    fire(3);
    wb(1'b1, RLS_ADDR_IRQ_STATUS, 32'h0000_000F);
    wb(1'b0, RLS_ADDR_IRQ_MASK, 32'h0);
    `CHK(q[3:0], RLS_MASK_RESET)
    wb(1'b1, RLS_ADDR_IRQ_MASK, 32'h0000_000F);
    for (int k = 0; k < 3; k++) begin
      fire(k);
      `CHK(irq_o, 1'b1)
      wb(1'b0, RLS_ADDR_IRQ_STATUS, 32'h0);
      `CHK(q[3:0], 4'(4'h1 << k))
      wb(1'b1, RLS_ADDR_IRQ_STATUS, 32'h0000_000F);
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
    end
    wb(1'b1, RLS_ADDR_IRQ_MASK, 32'h0);
    fire(0);
    `CHK(irq_o, 1'b0)
    wb(1'b0, RLS_ADDR_IRQ_STATUS, 32'h0);
    `CHK(q[0], 1'b1)
    $display("test interrupt done");
    conclude();
  end
endmodule // tb_rx_link_status_registers
`default_nettype wire
